// ==== rtl/txb_map.svh ====
/*
  constants of the transmit buffer control block: command codes, control
  register fields, buffer sizes and serial clock timing.
  assumes nothing; included by the package and both ends.
*/
`ifndef TXB_MAP_SVH
`define TXB_MAP_SVH
// command byte: code in bits 7..5, argument in bits 4..0
`define TXB_CMD_WR_BUF   3'h0
`define TXB_CMD_RD_BUF   3'h1
`define TXB_CMD_WR_CTRL  3'h2
`define TXB_CMD_RD_STAT  3'h4
`define TXB_CMD_DEL_IRQ  3'h5
// control register 1 fields
`define TXB_OP_TX        3'h1
`define TXB_CR1_TRANSP   3
`define TXB_CR1_PATTERN  4
`define TXB_CR1_LVL_LO   5
`define TXB_CR1_FDX      7
// buffer and timing
`define TXB_DEPTH        16
`define TXB_THR_MAX      5'h10
`define TXB_HALF_SHIFT   3'h3
`define TXB_SCLK_HALF    8
// host register byte offsets and the two-byte bit of a command write
`define TXB_H_CMD        4'h0
`define TXB_H_RESP       4'h4
`define TXB_H_DIRECT     4'h8
`define TXB_H_TWO_BYTES  16
`endif

// ==== rtl/txb_pkg.sv ====
/*
  types shared by both ends of the transmit buffer control block.
  assumes txb_map.svh is on the include path.
*/
`include "txb_map.svh"
package txb_pkg;
  // device transmit sequencing
  typedef enum logic [2:0] {
    TXB_IDLE    = 3'b001,
    TXB_STARTUP = 3'b010,
    TXB_ACTIVE  = 3'b100
  } txb_tx_state_t;
  // host serial frame sequencing
  typedef enum logic [3:0] {
    TXB_H_IDLE = 4'b0001,
    TXB_H_LOW  = 4'b0010,
    TXB_H_HIGH = 4'b0100,
    TXB_H_END  = 4'b1000
  } txb_host_state_t;
endpackage

// ==== rtl/txb_if.sv ====
/*
  four-wire serial link plus interrupt pin between host and device.
  assumes the host drives sclk, cs_n and sdi; the device drives sdo, irq.
*/
`timescale 1ns/1ps
interface txb_if;
  logic sclk;   // serial clock, made by the host
  logic cs_n;   // frame select, active low
  logic sdi;    // host to device data, or direct tx level
  logic sdo;    // device to host data
  logic irq;    // interrupt, active high level
  modport dev  (input sclk, cs_n, sdi, output sdo, irq);
  modport host (output sclk, cs_n, sdi, input sdo, irq);
endinterface

// ==== rtl/txb_dev.sv ====
/*
  device end: control registers, 16 byte transmit buffer with byte counter,
  automatic manchester / nrz / transparent transmitter and interrupt pin.
  assumes link pins are asynchronous to clk and a pll lock input from
  the synthesizer.
*/
`timescale 1ns/1ps
`include "txb_map.svh"
module txb_dev
  import txb_pkg::*;
#(
  parameter int DEPTH = `TXB_DEPTH
)(
  // clock, reset, enable
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // serial link
  txb_if.dev        lnk,
  // radio side
  input  wire logic pll_lock_in,
  input  wire logic power_on_in,
  input  wire logic power_loss_in,
  input  wire logic rx_level_evt,
  input  wire logic rx_err_evt,
  input  wire logic bitcheck_ok_evt,
  output logic      pll_en,
  output logic      tx_on,
  output logic      tx_level,
  output logic      amplitude_not_frequency_sel
);
  generate
    if (DEPTH != 16)
      $error("txb_dev: depth must be 16");
  endgenerate

  // ==========================================================
  // input synchronisers
  wire  [5:0] async_in;      // raw asynchronous inputs
  logic       s1 [6];        // first stage
  logic       s2 [6];        // second stage
  assign async_in = {lnk.sclk, lnk.cs_n, lnk.sdi, pll_lock_in, power_on_in, power_loss_in};
  for (genvar i = 0; i < 6; i++) begin : g_sync
    // two flops per asynchronous input
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
      end else if (ce) begin
        s1[i] <= async_in[i];
        s2[i] <= s1[i];
      end
    end
  end
  wire sclk_s = s2[5];
  wire cs_n_s = s2[4];
  wire sdi_s  = s2[3];
  wire lock_s = s2[2];
  wire pon_s  = s2[1];
  wire ploss_s = s2[0];

  // ==========================================================
  // serial command decoder
  logic       sclk_d, pon_d, ploss_d;  // previous synchronised levels
  logic [2:0] bitcnt_reg;              // bit within byte
  logic [7:0] shin_reg;                // incoming shift
  logic       first_reg;               // next byte is a command
  logic [2:0] cmd_reg;                 // current command code
  logic [4:0] arg_reg;                 // current command argument
  logic       rd_active_reg;           // host is reading the buffer
  logic [7:0] dout_reg;                // outgoing shift
  logic       sdo_reg, irq_reg;
  logic [7:0] ctrl_reg [8];            // control registers 0..7
  logic [4:0] thr_reg;                 // start threshold

  wire       rise = sclk_s & ~sclk_d;
  wire       fall = ~sclk_s & sclk_d;
  wire       byte_done = rise & ~cs_n_s & (bitcnt_reg == 3'h7);
  wire [7:0] byte_val  = {shin_reg[6:0], sdi_s};
  wire       cmd_done  = byte_done & first_reg;
  wire       data_done = byte_done & ~first_reg;
  wire [2:0] op        = ctrl_reg[1][2:0];
  wire       transp    = ctrl_reg[1][`TXB_CR1_TRANSP];
  wire       pattern   = ctrl_reg[1][`TXB_CR1_PATTERN];
  wire [1:0] lvl_sel   = ctrl_reg[1][`TXB_CR1_LVL_LO +: 2];
  wire       fdx       = ctrl_reg[1][`TXB_CR1_FDX];
  wire       ctrl_wr   = data_done & (cmd_reg == `TXB_CMD_WR_CTRL);
  wire       ctrl_clr  = ctrl_wr & (arg_reg[2:0] == 3'h1 || arg_reg[2:0] >= 3'h4);
  wire       stat_rd   = cmd_done & (byte_val[7:5] == `TXB_CMD_RD_STAT);
  wire       del_irq   = cmd_done & (byte_val[7:5] == `TXB_CMD_DEL_IRQ);
  wire       rd_byte   = cmd_done ? (byte_val[7:5] == `TXB_CMD_RD_BUF)
                                  : (data_done & cmd_reg == `TXB_CMD_RD_BUF);

  // edge history
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      sclk_d  <= 1'b0;
      pon_d   <= 1'b0;
      ploss_d <= 1'b0;
    end else if (ce) begin
      sclk_d  <= sclk_s;
      pon_d   <= pon_s;
      ploss_d <= ploss_s;
    end
  end

  // bit and byte framing, command latch
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      bitcnt_reg    <= 3'h0;
      shin_reg      <= 8'h00;
      first_reg     <= 1'b1;
      cmd_reg       <= 3'h0;
      arg_reg       <= 5'h00;
      thr_reg       <= 5'h00;
      rd_active_reg <= 1'b0;
    end else if (ce) begin
      if (cs_n_s) begin
        // frame ended: restart at a command byte
        bitcnt_reg    <= 3'h0;
        first_reg     <= 1'b1;
        rd_active_reg <= 1'b0;
      end else if (rise) begin
        bitcnt_reg <= bitcnt_reg + 3'h1;
        shin_reg   <= byte_val;
      end
      if (cmd_done) begin
        first_reg     <= 1'b0;
        cmd_reg       <= byte_val[7:5];
        arg_reg       <= byte_val[4:0];
        rd_active_reg <= (byte_val[7:5] == `TXB_CMD_RD_BUF);
        if (byte_val[7:5] == `TXB_CMD_WR_BUF)
          thr_reg <= (byte_val[4:0] > `TXB_THR_MAX) ? `TXB_THR_MAX : byte_val[4:0];
      end
    end
  end

  // control register writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      for (int k = 0; k < 8; k++)
        ctrl_reg[k] <= 8'h00;
    end else if (ce && ctrl_wr) begin
      ctrl_reg[arg_reg[2:0]] <= byte_val;
    end
  end

  // ==========================================================
  // transmit sequencing
  txb_tx_state_t st_reg, st_next;
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      TXB_IDLE:    if (op == `TXB_OP_TX) st_next = TXB_STARTUP;
      TXB_STARTUP: if (lock_s) st_next = TXB_ACTIVE;
      TXB_ACTIVE:  st_next = TXB_ACTIVE;
      default:     st_next = TXB_IDLE;
    endcase
    if (op != `TXB_OP_TX)
      st_next = TXB_IDLE;
  end

  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) st_reg <= TXB_IDLE;
    else if (ce) st_reg <= st_next;
  end

  // ==========================================================
  // buffer and pending byte counter
  logic [7:0] mem [DEPTH];
  logic [3:0] wp_reg, rp_reg;
  logic [4:0] cnt_reg, cnt_next;
  logic       busy_reg, started_reg, tx_done;
  wire        flush    = ctrl_clr & (st_reg != TXB_IDLE);
  wire        buf_push = data_done & (cmd_reg == `TXB_CMD_WR_BUF) & ~transp
                       & (st_reg != TXB_IDLE) & (cnt_reg < 5'(DEPTH));
  wire        buf_pop  = rd_byte & (cnt_reg != 5'h00);
  wire        tx_load  = ~busy_reg & (st_reg == TXB_ACTIVE) & ~transp & ~buf_pop
                       & (cnt_reg != 5'h00) & (started_reg | cnt_reg >= thr_reg);

  always_comb
  begin
    cnt_next = cnt_reg + {4'h0, buf_push} - {4'h0, buf_pop} - {4'h0, tx_done};
    if (flush)
      cnt_next = 5'h00;
  end

  // storage, pointers and counter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      wp_reg  <= 4'h0;
      rp_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      if (flush) begin
        wp_reg <= 4'h0;
        rp_reg <= 4'h0;
      end else begin
        if (buf_push) begin
          mem[wp_reg] <= byte_val;
          wp_reg      <= wp_reg + 4'h1;
        end
        if (buf_pop || tx_load)
          rp_reg <= rp_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // bit timing and symbol shaping
  logic [13:0] tim_reg;
  logic        half_reg;
  logic [2:0]  bitn_reg;
  logic [7:0]  txsh_reg;
  wire  [13:0] half_len = (14'(ctrl_reg[7][5:0]) + 14'h0001)
                        << ({1'b0, ctrl_reg[6][7:6]} + `TXB_HALF_SHIFT);
  wire         tick = busy_reg & (tim_reg == half_len - 14'h0001);
  assign tx_done = tick & half_reg & (bitn_reg == 3'h7);

  // byte serialiser, msb first
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      busy_reg    <= 1'b0;
      started_reg <= 1'b0;
      tim_reg     <= 14'h0000;
      half_reg    <= 1'b0;
      bitn_reg    <= 3'h0;
      txsh_reg    <= 8'h00;
    end else if (ce) begin
      if (flush || st_reg != TXB_ACTIVE) begin
        busy_reg    <= 1'b0;
        started_reg <= 1'b0;
      end else if (tx_load) begin
        busy_reg    <= 1'b1;
        started_reg <= 1'b1;
        txsh_reg    <= mem[rp_reg];
        tim_reg     <= 14'h0000;
        half_reg    <= 1'b0;
        bitn_reg    <= 3'h0;
      end else if (tick) begin
        tim_reg  <= 14'h0000;
        half_reg <= ~half_reg;
        if (half_reg) begin
          txsh_reg <= {txsh_reg[6:0], 1'b0};
          bitn_reg <= bitn_reg + 3'h1;
          if (bitn_reg == 3'h7)
            busy_reg <= 1'b0;
        end
      end else if (busy_reg) begin
        tim_reg <= tim_reg + 14'h0001;
      end
    end
  end

  // modulator outputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      pll_en   <= 1'b0;
      tx_on    <= 1'b0;
      tx_level <= 1'b0;
      amplitude_not_frequency_sel <= 1'b0;
    end else if (ce) begin
      pll_en <= (st_reg != TXB_IDLE);
      tx_on  <= (st_reg == TXB_ACTIVE) & (busy_reg | transp);
      amplitude_not_frequency_sel <= ctrl_reg[4][0];
      if (transp) begin
        if (cs_n_s)
          tx_level <= sdi_s;
      end else if (pattern)
        tx_level <= busy_reg & txsh_reg[7];
      else
        tx_level <= busy_reg & (txsh_reg[7] ~^ half_reg);
    end
  end

  // ==========================================================
  // interrupt flags, set wins over clear
  logic stat_flag, tx_flag, rx_flag, dup_flag;
  wire [4:0] lvl_val = (lvl_sel == 2'h0) ? 5'h01 : (lvl_sel == 2'h1) ? 5'h02 :
                       (lvl_sel == 2'h2) ? 5'h04 : 5'h0c;
  wire stat_ev = (ploss_s ^ ploss_d) | (pon_s & ~pon_d);
  wire tx_ev   = ~fdx & ~transp & (st_reg != TXB_IDLE) & (cnt_next != cnt_reg)
               & ((cnt_next == lvl_val) | (tx_done & cnt_next == 5'h00));
  wire rx_ev   = ~transp & ((~rd_active_reg & ~rd_byte & (rx_level_evt | rx_err_evt))
               | (bitcheck_ok_evt & ~pattern));
  wire dup_ev  = fdx & tx_done & (cnt_next == 5'h00);

  // sticky interrupt sources
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      stat_flag <= 1'b0;
      tx_flag   <= 1'b0;
      rx_flag   <= 1'b0;
      dup_flag  <= 1'b0;
    end else if (ce) begin
      stat_flag <= stat_ev | (stat_flag & ~(stat_rd | del_irq));
      tx_flag   <= tx_ev | (tx_flag & ~(buf_push | ctrl_clr | del_irq));
      rx_flag   <= rx_ev | (rx_flag & ~(buf_pop | ctrl_clr | del_irq));
      dup_flag  <= dup_ev | (dup_flag & ~(buf_pop | ctrl_clr | del_irq));
    end
  end

  // ==========================================================
  // serial answer and pins
  wire [7:0] status = {pon_s, ploss_s, busy_reg, cnt_reg};
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      dout_reg <= 8'h00;
      sdo_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end else if (ce) begin
      if (stat_rd)
        dout_reg <= status;
      else if (buf_pop)
        dout_reg <= mem[rp_reg];
      else if (fall && !cs_n_s && bitcnt_reg != 3'h0)
        dout_reg <= {dout_reg[6:0], 1'b0};
      sdo_reg <= dout_reg[7];
      irq_reg <= stat_flag | tx_flag | rx_flag | dup_flag;
    end
  end
  assign lnk.sdo = sdo_reg;
  assign lnk.irq = irq_reg;
endmodule

// ==== rtl/txb_host.sv ====
/*
  host end: takes command frames from software over avalon-mm and plays
  them on the four-wire link, making sclk by dividing clk.
  assumes sdo and irq from the device are asynchronous to clk.
*/
`timescale 1ns/1ps
`include "txb_map.svh"
module txb_host
  import txb_pkg::*;
#(
  parameter int HALF = `TXB_SCLK_HALF
)(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // serial link
  txb_if.host              lnk
);
  generate
    if (HALF < 8 || HALF > 255)
      $error("txb_host: HALF must be 8..255");
  endgenerate

  // ==========================================================
  // synchronisers for sdo and irq
  wire  [1:0] async_in = {lnk.sdo, lnk.irq};
  logic       s1 [2];
  logic       s2 [2];
  for (genvar i = 0; i < 2; i++) begin : g_sync
    // two flops per input
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
      end else if (ce) begin
        s1[i] <= async_in[i];
        s2[i] <= s1[i];
      end
    end
  end

  // ==========================================================
  // register access
  txb_host_state_t st_reg;
  logic [15:0] shout_reg;   // outgoing bits, msb first
  logic [7:0]  shin_reg;    // last byte received
  logic        two_reg;     // frame has a second byte
  logic        direct_reg;  // sdi level while no frame runs
  wire         busy  = (st_reg != TXB_H_IDLE);
  wire         req   = avs_read | avs_write;
  wire         stall = avs_write & (avs_address == `TXB_H_CMD) & busy;
  wire         go    = avs_write & ~avs_waitrequest & (avs_address == `TXB_H_CMD);

  // waitrequest and read data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      direct_reg      <= 1'b0;
    end else if (ce) begin
      avs_waitrequest <= ~(req & avs_waitrequest & ~stall);
      if (req && avs_waitrequest) begin
        case (avs_address)
          `TXB_H_RESP:   avs_readdata <= {22'h0, s2[0], busy, shin_reg};
          `TXB_H_DIRECT: avs_readdata <= {31'h0, direct_reg};
          default:       avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (avs_write && !avs_waitrequest && avs_address == `TXB_H_DIRECT)
        direct_reg <= avs_writedata[0];
    end
  end

  // ==========================================================
  // frame engine
  logic [7:0] ph_reg;    // phase timer
  logic [3:0] bit_reg;   // bit index in frame
  logic       sclk_reg, cs_n_reg, sdi_reg;
  wire        ph_end = (ph_reg == 8'(HALF - 1));
  wire        last   = (bit_reg == (two_reg ? 4'hf : 4'h7));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) begin
      st_reg    <= TXB_H_IDLE;
      ph_reg    <= 8'h00;
      bit_reg   <= 4'h0;
      shout_reg <= 16'h0000;
      shin_reg  <= 8'h00;
      two_reg   <= 1'b0;
      sclk_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
      sdi_reg   <= 1'b0;
    end else if (ce) begin
      ph_reg <= ph_end ? 8'h00 : ph_reg + 8'h01;
      case (st_reg)
        TXB_H_IDLE:
        begin
          sdi_reg <= direct_reg;
          ph_reg  <= 8'h00;
          if (go) begin
            // command byte goes first, data byte second
            shout_reg <= {avs_writedata[7:0], avs_writedata[15:8]};
            two_reg   <= avs_writedata[`TXB_H_TWO_BYTES];
            cs_n_reg  <= 1'b0;
            sdi_reg   <= avs_writedata[7];
            bit_reg   <= 4'h0;
            st_reg    <= TXB_H_LOW;
          end
        end
        TXB_H_LOW:
          if (ph_end) begin
            shin_reg <= {shin_reg[6:0], s2[1]};
            sclk_reg <= 1'b1;
            st_reg   <= TXB_H_HIGH;
          end
        TXB_H_HIGH:
          if (ph_end) begin
            sclk_reg <= 1'b0;
            if (last)
              st_reg <= TXB_H_END;
            else begin
              shout_reg <= {shout_reg[14:0], 1'b0};
              sdi_reg   <= shout_reg[14];
              bit_reg   <= bit_reg + 4'h1;
              st_reg    <= TXB_H_LOW;
            end
          end
        TXB_H_END:
          if (ph_end) begin
            cs_n_reg <= 1'b1;
            st_reg   <= TXB_H_IDLE;
          end
        default: st_reg <= TXB_H_IDLE;
      endcase
    end
  end
  assign lnk.sclk = sclk_reg;
  assign lnk.cs_n = cs_n_reg;
  assign lnk.sdi  = sdi_reg;
endmodule

// ==== verif/txb_monitor.sv ====
/*
  assertions on the four-wire link between host and device.
  assumes the host runs with a half sclk period of 8 clk cycles.
*/
`timescale 1ns/1ps
module txb_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic irq
);
  // ========================================
  // helper counters
  logic       sclk_q;   // sclk one cycle back
  logic [4:0] rise_cnt; // sclk rises in this frame
  logic [3:0] idle_cnt; // cycles with cs_n high, saturating
  // count rises per frame and idle time
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q   <= 1'b0;
      rise_cnt <= 5'h0;
      idle_cnt <= 4'h0;
    end
    else
    begin
      sclk_q   <= sclk;
      rise_cnt <= cs_n ? 5'h0 : rise_cnt + 5'(sclk & ~sclk_q);
      idle_cnt <= !cs_n ? 4'h0 : idle_cnt + 4'(idle_cnt != 4'hf);
    end
  end
  // ========================================
  // link properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("sclk moves outside a frame");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("sclk high phase wrong");
  AST_SCLK_LOW: assert property ($fell(sclk) && !cs_n |-> !sclk[*8])
    else $error("sclk low phase too short");
  AST_SDI_HOLD: assert property (!cs_n && sclk |-> $stable(sdi))
    else $error("sdi changes while sclk high");
  AST_FRAME_START: assert property ($fell(cs_n) |-> !sclk[*4] ##[1:12] sclk)
    else $error("first sclk rise misplaced");
  AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_cnt == 5'h8 || rise_cnt == 5'h10)
    else $error("frame is not whole bytes");
  AST_FRAME_END: assert property ($rose(cs_n) |-> !sclk && !$past(sclk, 6))
    else $error("frame ends too soon after sclk");
  AST_IRQ_HELD: assert property ($fell(irq) |-> idle_cnt < 4'h8)
    else $error("irq drops without a clearing frame");
endmodule

// ==== verif/testbench.sv ====
/*
  testbench: host and device joined by the link, driven over avalon-mm.
  assumes host HALF 8 and rate settings giving 8 clk half bits.
*/
`timescale 1ns/1ps
module testbench;
  import txb_pkg::*;
  // ========================================
  // signals
  logic        clk, nrst, rd, wr, wreq, lock, pwr_on, pwr_loss;
  logic        pll_en, tx_on, tx_level, amp;
  logic        ce, rx_lvl, bchk;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, rdata_q;
  int          err_count, n_tests;
  txb_if lnk();
  txb_host #(.HALF(8)) txb_host_i (.clk(clk), .nrst(nrst), .ce(ce),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .lnk(lnk.host));
  txb_dev txb_dev_i (.clk(clk), .nrst(nrst), .ce(ce), .lnk(lnk.dev),
    .pll_lock_in(lock), .power_on_in(pwr_on), .power_loss_in(pwr_loss),
    .rx_level_evt(rx_lvl), .rx_err_evt(1'b0), .bitcheck_ok_evt(bchk),
    .pll_en(pll_en), .tx_on(tx_on), .tx_level(tx_level),
    .amplitude_not_frequency_sel(amp));
  txb_monitor txb_monitor_i (.clk(clk), .nrst(nrst), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .sdi(lnk.sdi), .irq(lnk.irq));
  always #5 clk = ~clk;
  // ========================================
  // shared tasks
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  // only the watchdog ends a wait that never sees waitrequest low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    rdata_q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // poll the response register until no frame runs
  task automatic idle_wait();
    do
      av(1'b0, 4'h4, 32'h0);
    while (rdata_q[8] !== 1'b0);
  endtask
  // two-byte frame, then poll until the frame is over
  task automatic cmd(input logic [7:0] c, input logic [7:0] d);
    av(1'b1, 4'h0, {15'h0, 1'b1, d, c});
    idle_wait();
  endtask
  // ========================================
  // scenarios
  task automatic t_power();
    pwr_loss <= 1'b1;
    wait_clk(50);
    chk("irq held", 8'h1, {7'h0, lnk.irq});
    cmd(8'h80, 8'h00);
    chk("status", 8'h40, rdata_q[7:0]);
    chk("irq read", 8'h0, {7'h0, lnk.irq});
    pwr_on <= 1'b1;
    wait_clk(10);
    chk("irq on", 8'h1, {7'h0, lnk.irq});
    cmd(8'ha0, 8'h00);
    chk("irq del", 8'h0, {7'h0, lnk.irq});
  endtask
  // one byte sent in pattern or manchester coding
  task automatic t_tx(input logic pat, input logic [7:0] d);
    cmd(8'h41, 8'h00);
    cmd(8'h46, 8'h00);
    cmd(8'h47, 8'h00);
    cmd(8'h44, 8'h01);
    chk("amp", 8'h1, {7'h0, amp});
    lock <= 1'b0;
    cmd(8'h41, {3'h0, pat, 4'h1});
    chk("pll_en", 8'h1, {7'h0, pll_en});
    // byte loaded while the pll is still unlocked
    cmd(8'h01, d);
    chk("startup", 8'h0, {7'h0, tx_on});
    cmd(8'h80, 8'h00);
    chk("loaded", 8'hc1, rdata_q[7:0]);
    chk("irq level", 8'h1, {7'h0, lnk.irq});
    cmd(8'ha0, 8'h00);
    chk("irq del tx", 8'h0, {7'h0, lnk.irq});
    lock <= 1'b1;
    while (tx_on !== 1'b1)
      @(posedge clk);
    wait_clk(3);
    for (int i = 7; i >= 0; i--)
    begin
      chk("half1", {7'h0, pat ? d[i] : ~d[i]}, {7'h0, tx_level});
      wait_clk(8);
      chk("half2", {7'h0, d[i]}, {7'h0, tx_level});
      wait_clk(8);
    end
    wait_clk(20);
    chk("irq empty", 8'h1, {7'h0, lnk.irq});
    cmd(8'h80, 8'h00);
    chk("count", 8'hc0, rdata_q[7:0]);
    chk("irq kept", 8'h1, {7'h0, lnk.irq});
    cmd(8'h44, 8'h01);
    chk("irq wr4", 8'h0, {7'h0, lnk.irq});
  endtask
  task automatic t_flush();
    cmd(8'h10, 8'h3c);
    cmd(8'h80, 8'h00);
    chk("held", 8'hc1, rdata_q[7:0]);
    cmd(8'h45, 8'h00);
    cmd(8'h80, 8'h00);
    chk("flushed", 8'hc0, rdata_q[7:0]);
    cmd(8'h41, 8'h00);
    chk("idle", 8'h0, {7'h0, pll_en});
  endtask
  task automatic t_transp();
    cmd(8'h41, 8'h09);
    wait_clk(20);
    for (int v = 0; v < 2; v++)
    begin
      av(1'b1, 4'h8, 32'(v));
      wait_clk(10);
      chk("direct", 8'(v), {7'h0, tx_level});
    end
    cmd(8'h00, 8'h55);
    cmd(8'h80, 8'h00);
    chk("no buffer", 8'hc0, rdata_q[7:0]);
    av(1'b0, 4'hc, 32'h0);
    chk("unmapped", 8'h0, rdata_q[7:0]);
  endtask
  // clock enable freeze, receive events and read suppression
  task automatic t_rx();
    cmd(8'h41, 8'h00);
    ce <= 1'b0;
    pwr_loss <= 1'b0;
    wait_clk(20);
    chk("ce frozen", 8'h0, {7'h0, lnk.irq});
    ce <= 1'b1;
    wait_clk(10);
    chk("ce resumed", 8'h1, {7'h0, lnk.irq});
    cmd(8'h80, 8'h00);
    chk("status loss", 8'h80, rdata_q[7:0]);
    rx_lvl <= 1'b1;
    wait_clk(1);
    rx_lvl <= 1'b0;
    wait_clk(5);
    chk("irq rx", 8'h1, {7'h0, lnk.irq});
    cmd(8'ha0, 8'h00);
    chk("irq rx del", 8'h0, {7'h0, lnk.irq});
    // receive event while a buffer read frame runs
    av(1'b1, 4'h0, {15'h0, 1'b1, 8'h00, 8'h20});
    wait_clk(150);
    rx_lvl <= 1'b1;
    wait_clk(1);
    rx_lvl <= 1'b0;
    idle_wait();
    chk("irq rd", 8'h0, {7'h0, lnk.irq});
    bchk <= 1'b1;
    wait_clk(1);
    bchk <= 1'b0;
    wait_clk(5);
    chk("irq bitcheck", 8'h1, {7'h0, lnk.irq});
    cmd(8'h41, 8'h00);
    chk("irq ctrl1", 8'h0, {7'h0, lnk.irq});
  endtask
  // ========================================
  // verdict, main sequence and watchdog
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {clk, nrst, rd, wr, lock, pwr_on, pwr_loss, rx_lvl, bchk} = 9'h0;
    ce = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    err_count = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_power();
    t_tx(1'b1, 8'ha5);
    t_tx(1'b0, 8'h3c);
    t_flush();
    t_transp();
    t_rx();
    complete_run();
  end
  // about 40k cycles, several times the expected run length
  initial
  begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule
